// [temp_sensor_pkg.sv]
// Shared constants, types and register map of the temperature sensor block
package temp_sensor_pkg;

    // Clock rate and conversion timing
    localparam int CLK_MHZ            = 50;
    localparam int PERIOD_16HZ_US     = 62500;
    localparam int CONV_CHAN_US       = 60000;
    localparam int PERIOD_16HZ_CYCLES = PERIOD_16HZ_US * CLK_MHZ;
    localparam int CONV_CHAN_CYCLES   = CONV_CHAN_US * CLK_MHZ;

    // Slave address, value is arbitrary
    localparam logic [6:0] DEV_ADDR = 7'h2A;

    // Command codes
    localparam logic [7:0] CMD_LOCAL_INT   = 8'h00;
    localparam logic [7:0] CMD_REMOTE_INT  = 8'h01;
    localparam logic [7:0] CMD_STATUS      = 8'h02;
    localparam logic [7:0] CMD_CONFIG_RD   = 8'h03;
    localparam logic [7:0] CMD_RATE_RD     = 8'h04;
    localparam logic [7:0] CMD_CONFIG_WR   = 8'h09;
    localparam logic [7:0] CMD_RATE_WR     = 8'h0A;
    localparam logic [7:0] CMD_ONE_SHOT    = 8'h0F;
    localparam logic [7:0] CMD_REMOTE_FRAC = 8'h10;
    localparam logic [7:0] CMD_LOCAL_FRAC  = 8'h11;

    // Reset values, field positions and rate codes
    localparam logic [7:0]  CONFIG_POR      = 8'h20;
    localparam logic [7:0]  RATE_POR        = 8'h08;
    localparam logic [7:0]  RATE_MAX        = 8'h08;
    localparam logic [7:0]  RATE_EXT_MAX    = 8'h06;
    localparam logic [7:0]  TEMP_POR        = 8'h00;
    localparam logic [7:0]  PTR_POR         = 8'h00;
    localparam int          CFG_HALT_BIT    = 6;
    localparam int          STATUS_BUSY_BIT = 7;
    localparam int          SMP_W           = 11;
    localparam logic [31:0] PERIOD_CNT_POR  = 32'hFFFF_FFFF;

    // Conversion sequencer states
    typedef enum logic [1:0] {
        CV_IDLE   = 2'h0,
        CV_LOCAL  = 2'h1,
        CV_REMOTE = 2'h3
    } conv_state_e;

    // Serial link states
    typedef enum logic [2:0] {
        LK_IDLE = 3'h0,
        LK_ADDR = 3'h1,
        LK_AACK = 3'h3,
        LK_RXB  = 3'h2,
        LK_RACK = 3'h6,
        LK_TXB  = 3'h7,
        LK_TACK = 3'h5
    } link_state_e;

    // Events from the serial link to the register file
    typedef struct packed {
        logic       cmd_valid;
        logic       data_valid;
        logic       stop;
        logic       rd_req;
        logic [7:0] data;
    } smb_evt_s;

endpackage

// [smbus_slave.sv]
// Byte-level SMBus slave engine with open-drain data drive
`timescale 1ns/1ns
module smbus_slave
    import temp_sensor_pkg::*;
(
    // Clock and control
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       ce_i,
    // Bus pins
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_oe_n_o,
    // Register side
    input  wire logic [7:0] rd_data_i,
    output smb_evt_s        evt_o
);

    link_state_e st_reg, st_next;
    logic        scl_reg, sda_reg;
    logic [3:0]  cnt_reg, cnt_next;
    logic [7:0]  sh_reg, sh_next;
    logic        rw_reg, rw_next;
    logic        first_reg, first_next;
    logic        drv_reg, drv_next;
    smb_evt_s    evt_reg, evt_next;

    // Bus edge and condition decode
    wire rise      = ~scl_reg & scl_i;
    wire fall      = scl_reg & ~scl_i;
    wire start_c   = scl_reg & scl_i & sda_reg & ~sda_i;
    wire stop_c    = scl_reg & scl_i & ~sda_reg & sda_i;
    wire byte_done = (cnt_reg == 4'h8);

    // Next state of the link
    always_comb begin
        st_next    = st_reg;
        cnt_next   = cnt_reg;
        sh_next    = sh_reg;
        rw_next    = rw_reg;
        first_next = first_reg;
        drv_next   = drv_reg;
        evt_next   = '0;
        if (start_c) begin
            st_next    = LK_ADDR;
            cnt_next   = 4'h0;
            drv_next   = 1'b0;
            first_next = 1'b1;
        end else if (stop_c) begin
            st_next       = LK_IDLE;
            drv_next      = 1'b0;
            evt_next.stop = 1'b1;
        end else begin
            unique case (st_reg)
                LK_IDLE: begin
                end
                LK_ADDR, LK_RXB: begin
                    if (rise) begin
                        sh_next  = {sh_reg[6:0], sda_i};
                        cnt_next = cnt_reg + 4'h1;
                    end else if (fall && byte_done) begin
                        cnt_next = 4'h0;
                        if (st_reg == LK_ADDR) begin
                            // One address reaches every register
                            st_next  = (sh_reg[7:1] == DEV_ADDR) ? LK_AACK : LK_IDLE; // R9
                            drv_next = (sh_reg[7:1] == DEV_ADDR);
                            rw_next  = sh_reg[0];
                        end else begin
                            st_next             = LK_RACK;
                            drv_next            = 1'b1;
                            first_next          = 1'b0;
                            evt_next.cmd_valid  = first_reg; // R11
                            evt_next.data_valid = ~first_reg;
                            evt_next.data       = sh_reg;
                        end
                    end
                end
                LK_AACK, LK_RACK: begin
                    if (fall && rw_reg) begin
                        st_next         = LK_TXB;
                        sh_next         = rd_data_i;
                        drv_next        = ~rd_data_i[7]; // R14
                        evt_next.rd_req = 1'b1;
                    end else if (fall) begin
                        st_next  = LK_RXB;
                        drv_next = 1'b0;
                    end
                end
                LK_TXB: begin
                    if (rise) begin
                        cnt_next = cnt_reg + 4'h1;
                    end else if (fall && byte_done) begin
                        st_next  = LK_TACK;
                        cnt_next = 4'h0;
                        drv_next = 1'b0;
                    end else if (fall) begin
                        sh_next  = {sh_reg[6:0], 1'b0}; // R14
                        drv_next = ~sh_reg[6];
                    end
                end
                LK_TACK: begin
                    if (rise) begin
                        st_next = sda_i ? LK_IDLE : LK_AACK;
                    end
                end
                default: begin
                    st_next = LK_IDLE;
                end
            endcase
        end
    end

    // Link registers
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            {scl_reg, sda_reg} <= 2'h3;
            st_reg             <= LK_IDLE;
            {cnt_reg, sh_reg}  <= 12'h000;
            {rw_reg, first_reg, drv_reg} <= 3'h0;
            evt_reg            <= '0;
        end else if (ce_i) begin
            {scl_reg, sda_reg} <= {scl_i, sda_i};
            st_reg             <= st_next;
            {cnt_reg, sh_reg}  <= {cnt_next, sh_next};
            {rw_reg, first_reg, drv_reg} <= {rw_next, first_next, drv_next};
            evt_reg            <= evt_next;
        end
    end

    assign sda_oe_n_o = ~drv_reg;
    assign evt_o      = evt_reg;

endmodule

// [temp_sensor_smbus_standby.sv]
// Temperature sensor core: SMBus registers, conversion sequencer and standby control
// How it works
// R1: Standby keeps the converter off and starts no automatic conversions.
// R2: A low sleep request pin puts the device into hardware standby.
// R3: Configuration halt bit set means software standby; clear means free-running conversions.
// R4: Standby keeps every register and keeps answering bus transfers.
// R5: A one-shot command in software standby runs one conversion sequence.
// R6: A one-shot command in hardware standby is ignored.
// R7: The sleep pin overrides every software conversion request.
// R8: Standby arriving mid-conversion aborts it and leaves the results untouched.
// R9: One slave address reaches every register and function.
// R10: Write, Read, Send and Receive Byte transfers; all registers are 8 bits.
// R11: Last command byte stays as pointer for later Receive Byte reads.
// R12: Integer local and remote readings sit at 00h and 01h, always readable.
// R13: Integer readings are two's complement, one degree per step.
// R14: Every transmitted byte goes out most significant bit first.
// R15: At 4Hz or slower, 10h and 11h hold three fraction bits.
// R16: Integer and fraction registers of both channels update together at completion.
// R17: The host halts conversions via bit 6 before reading extended data.
// R18: Command 0Fh sent alone triggers one conversion sequence.
// R19: Busy flag is 1 during a conversion and 0 once finished.
// R20: Reset selects 16Hz; extended data only valid at 4Hz or slower.
// R21: Every sequence measures local then remote; old results stay readable meanwhile.
// R22: Fraction bits sit in the top three positions; lower bits read zero.
`timescale 1ns/1ns
module temp_sensor_smbus_standby
    import temp_sensor_pkg::*;
#(
    parameter int PERIOD_CYC = PERIOD_16HZ_CYCLES,
    parameter int CHAN_CYC   = CONV_CHAN_CYCLES
)(
    // Clock, reset and enable
    input  wire logic             REF_CLK_I,
    input  wire logic             RESET_N_I,
    input  wire logic             CLK_EN_I,
    // SMBus pins
    input  wire logic             SMB_CLK_I,
    input  wire logic             SMB_DATA_I,
    output logic                  SMB_DATA_O,
    output logic                  SMB_DATA_OE_N_O,
    // Standby pin
    input  wire logic             SLEEP_REQUEST_PIN_N_I,
    // Converter interface
    input  wire logic [SMP_W-1:0] ADC_LOCAL_I,
    input  wire logic [SMP_W-1:0] ADC_REMOTE_I,
    output logic                  ADC_ENABLE_O,
    output logic                  ADC_CHANNEL_O
);

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Conversion period for a rate code, doubling per step below the top code
    function automatic logic [31:0] period_of(input logic [7:0] code, input logic [31:0] base);
        logic [7:0] c;
        c = (code > RATE_MAX) ? RATE_MAX : code;
        return base << (RATE_MAX - c);
    endfunction

    // Extended byte: three fraction bits on top, zero below
    function automatic logic [7:0] frac_of(input logic [SMP_W-1:0] s, input logic ext);
        return ext ? {s[2:0], 5'h00} : 8'h00;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Reset release

    logic rst_meta_reg;
    logic rst_n_sync;

    // Asynchronous assert, two-stage release
    always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            rst_meta_reg <= 1'b0;
            rst_n_sync   <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_sync   <= rst_meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Serial link

    smb_evt_s   evt;
    logic [7:0] rd_byte;

    smbus_slave u_link (
        .clk_i      (REF_CLK_I),
        .rst_n_i    (rst_n_sync),
        .ce_i       (CLK_EN_I), // R4
        .scl_i      (SMB_CLK_I),
        .sda_i      (SMB_DATA_I),
        .sda_oe_n_o (SMB_DATA_OE_N_O),
        .rd_data_i  (rd_byte),
        .evt_o      (evt)
    );

    // Open drain: only ever pulls low
    assign SMB_DATA_O = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    conv_state_e      cv_reg;
    logic [7:0]       ptr_reg;
    logic [7:0]       config_reg;
    logic [7:0]       rate_reg;
    logic [7:0]       local_int_reg;
    logic [7:0]       remote_int_reg;
    logic [7:0]       local_frac_reg;
    logic [7:0]       remote_frac_reg;
    logic [SMP_W-1:0] local_smp_reg;
    logic             os_pend_reg;
    logic [31:0]      period_cnt_reg;
    logic [31:0]      phase_cnt_reg;

    // Write decode from data bytes
    wire cfg_wr  = evt.data_valid && (ptr_reg == CMD_CONFIG_WR);
    wire rate_wr = evt.data_valid && (ptr_reg == CMD_RATE_WR);

    // Command pointer, kept across transfers
    always_ff @(posedge REF_CLK_I or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            ptr_reg <= PTR_POR;
        end else if (CLK_EN_I && evt.cmd_valid) begin
            ptr_reg <= evt.data; // R11 R10
        end
    end

    // Configuration and rate bytes
    always_ff @(posedge REF_CLK_I or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            config_reg <= CONFIG_POR;
            rate_reg   <= RATE_POR; // R20
        end else if (CLK_EN_I) begin
            if (cfg_wr) begin
                config_reg <= evt.data; // R3
            end
            if (rate_wr) begin
                rate_reg <= evt.data;
            end
        end
    end

    // One-shot command waits for the stop to prove no data byte followed
    always_ff @(posedge REF_CLK_I or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            os_pend_reg <= 1'b0;
        end else if (CLK_EN_I) begin
            if (evt.cmd_valid) begin
                os_pend_reg <= (evt.data == CMD_ONE_SHOT); // R18
            end else if (evt.data_valid || evt.stop) begin
                os_pend_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Conversion control

    wire [31:0] period_len = period_of(rate_reg, 32'(PERIOD_CYC));
    wire [31:0] chan_len   = 32'(CHAN_CYC);

    // Standby sources; the pin wins over every software request
    wire hw_sb      = ~SLEEP_REQUEST_PIN_N_I; // R2
    wire sw_sb      = config_reg[CFG_HALT_BIT]; // R3
    wire sw_sb_rise = cfg_wr && evt.data[CFG_HALT_BIT] && !sw_sb;
    wire busy       = (cv_reg != CV_IDLE);

    // Start and abort conditions
    wire os_fire    = evt.stop && os_pend_reg; // R18
    wire os_start   = os_fire && sw_sb && !hw_sb; // R5 R6 R7
    // A halt written in the very cycle a start falls due wins over that start
    wire auto_start = !hw_sb && !sw_sb && !sw_sb_rise && (period_cnt_reg >= period_len); // R1 R3 R7
    wire conv_start = !busy && (auto_start || os_start);
    wire abort      = busy && (hw_sb || sw_sb_rise); // R8
    wire phase_done = busy && (phase_cnt_reg == chan_len - 32'h1);
    wire commit     = (cv_reg == CV_REMOTE) && phase_done && !abort; // R16
    wire ext_ok     = (rate_reg <= RATE_EXT_MAX); // R15 R20

    // Sequencer: local channel then remote channel
    always_ff @(posedge REF_CLK_I or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            cv_reg <= CV_IDLE;
        end else if (CLK_EN_I) begin
            unique case (cv_reg)
                CV_IDLE: begin
                    if (conv_start) begin
                        cv_reg <= CV_LOCAL; // R21
                    end
                end
                CV_LOCAL: begin
                    if (abort) begin
                        cv_reg <= CV_IDLE; // R8
                    end else if (phase_done) begin
                        cv_reg <= CV_REMOTE; // R21
                    end
                end
                CV_REMOTE: begin
                    if (abort || phase_done) begin
                        cv_reg <= CV_IDLE;
                    end
                end
                default: begin
                    cv_reg <= CV_IDLE;
                end
            endcase
        end
    end

    // Phase timer and rate timer
    always_ff @(posedge REF_CLK_I or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            phase_cnt_reg  <= 32'h0;
            period_cnt_reg <= PERIOD_CNT_POR;
        end else if (CLK_EN_I) begin
            phase_cnt_reg <= (!busy || phase_done) ? 32'h0 : phase_cnt_reg + 32'h1;
            if (conv_start) begin
                period_cnt_reg <= 32'h0;
            end else if (period_cnt_reg != PERIOD_CNT_POR) begin
                period_cnt_reg <= period_cnt_reg + 32'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Results

    // Local sample is held until the remote channel completes
    always_ff @(posedge REF_CLK_I or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            local_smp_reg <= '0;
        end else if (CLK_EN_I && (cv_reg == CV_LOCAL) && phase_done) begin
            local_smp_reg <= ADC_LOCAL_I;
        end
    end

    // All four result bytes change in the same cycle, or not at all
    always_ff @(posedge REF_CLK_I or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            local_int_reg   <= TEMP_POR;
            remote_int_reg  <= TEMP_POR;
            local_frac_reg  <= TEMP_POR;
            remote_frac_reg <= TEMP_POR;
        end else if (CLK_EN_I && commit) begin
            local_int_reg   <= local_smp_reg[SMP_W-1:3]; // R13 R16
            remote_int_reg  <= ADC_REMOTE_I[SMP_W-1:3]; // R13
            local_frac_reg  <= frac_of(local_smp_reg, ext_ok); // R15 R22
            remote_frac_reg <= frac_of(ADC_REMOTE_I, ext_ok); // R22
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read selection

    // Status carries the busy flag
    wire [7:0] status_byte = 8'(busy) << STATUS_BUSY_BIT; // R19

    // Byte returned for the current pointer; unknown codes read zero
    assign rd_byte = (ptr_reg == CMD_LOCAL_INT)   ? local_int_reg   : // R12
                     (ptr_reg == CMD_REMOTE_INT)  ? remote_int_reg  : // R12
                     (ptr_reg == CMD_STATUS)      ? status_byte     :
                     (ptr_reg == CMD_CONFIG_RD)   ? config_reg      :
                     (ptr_reg == CMD_RATE_RD)     ? rate_reg        :
                     (ptr_reg == CMD_REMOTE_FRAC) ? remote_frac_reg : // R15
                     (ptr_reg == CMD_LOCAL_FRAC)  ? local_frac_reg  : 8'h00;

    // Converter control follows the sequencer
    assign ADC_ENABLE_O  = busy; // R1
    assign ADC_CHANNEL_O = (cv_reg == CV_REMOTE);

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (!rst_n_sync);

    a_standby_adc_off: assert property ( // R1
        CLK_EN_I && !busy && (hw_sb || sw_sb) && !os_start |=> !ADC_ENABLE_O)
        else $error("converter enabled in standby");

    a_pin_forces_idle: assert property ( // R7
        CLK_EN_I && hw_sb |=> cv_reg == CV_IDLE)
        else $error("conversion runs while sleep pin low");

    a_run_autostart: assert property ( // R3
        CLK_EN_I && !busy && !sw_sb && !hw_sb && period_cnt_reg >= period_len
        |=> cv_reg == CV_LOCAL)
        else $error("free-running conversion did not start");

    a_oneshot_runs: assert property ( // R5
        CLK_EN_I && !busy && evt.stop && os_pend_reg && sw_sb && !hw_sb
        |=> cv_reg == CV_LOCAL ##1 busy)
        else $error("one-shot did not start a sequence");

    a_abort_keeps: assert property ( // R8
        CLK_EN_I && abort |=> cv_reg == CV_IDLE && $stable(local_int_reg)
        && $stable(remote_int_reg) && $stable(local_frac_reg))
        else $error("aborted conversion changed results");

    a_pointer_held: assert property ( // R11
        CLK_EN_I && evt.cmd_valid |=> ptr_reg == $past(evt.data))
        else $error("pointer not loaded from command");

    a_commit_both: assert property ( // R16
        CLK_EN_I && commit |=> !busy && local_int_reg == $past(local_smp_reg[SMP_W-1:3])
        && remote_int_reg == $past(ADC_REMOTE_I[SMP_W-1:3]))
        else $error("results not updated together");

    a_busy_status: assert property ( // R19
        CLK_EN_I && conv_start |=> rd_byte[STATUS_BUSY_BIT] || ptr_reg != CMD_STATUS)
        else $error("busy flag missing during conversion");

    a_frac_low_zero: assert property ( // R22
        local_frac_reg[4:0] == 5'h00 && remote_frac_reg[4:0] == 5'h00)
        else $error("fraction low bits not zero");

    a_fast_no_frac: assert property ( // R20
        CLK_EN_I && commit && !ext_ok |=> local_frac_reg == 8'h00)
        else $error("fraction data at fast rate");

    a_rate_por: assert property ( // R20
        $rose(rst_n_sync) |-> rate_reg == RATE_POR)
        else $error("rate not at reset value");

    a_oneshot_pin_ignored: assert property ( // R6
        CLK_EN_I && !busy && os_fire && hw_sb |=> !busy)
        else $error("one-shot started while sleep pin low");

    a_local_first: assert property ( // R21
        CLK_EN_I && conv_start |=> cv_reg == CV_LOCAL && !ADC_CHANNEL_O)
        else $error("sequence did not begin on local channel");

    a_halt_stops_conv: assert property ( // R8
        CLK_EN_I && sw_sb_rise |=> !busy)
        else $error("halt write left a conversion running");

    c_oneshot: cover property (CLK_EN_I && os_start);
    c_abort: cover property (CLK_EN_I && abort);
    c_commit_ext: cover property (CLK_EN_I && commit && ext_ok);
    c_read: cover property (CLK_EN_I && evt.rd_req && ptr_reg == CMD_REMOTE_FRAC);

endmodule

// [smbus_host_model.sv]
// SMBus host master model driving the bus clock and an open-drain data line
`timescale 1ns/1ns
module smbus_host_model (
    // Clock and bus
    input  wire logic clk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_o
);
    localparam int HALF = 4; // Clocks per bus clock level, above the three the slave needs

    // Bus idles released
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end

    // Wait a number of system clocks
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // Start or repeated start: data falls while the clock is high
    task automatic start();
        sda_o <= 1'b1;
        wait_clk(HALF);
        scl_o <= 1'b1;
        wait_clk(HALF);
        sda_o <= 1'b0;
        wait_clk(HALF);
        scl_o <= 1'b0;
        wait_clk(HALF);
    endtask

    // Stop: data rises while the clock is high
    task automatic stop();
        sda_o <= 1'b0;
        wait_clk(HALF);
        scl_o <= 1'b1;
        wait_clk(HALF);
        sda_o <= 1'b1;
        wait_clk(HALF);
    endtask

    // One bit; the line is sampled at the end of the clock high phase
    task automatic xfer_bit(input logic b, output logic r);
        sda_o <= b;
        wait_clk(HALF);
        scl_o <= 1'b1;
        wait_clk(HALF);
        r = sda_i;
        scl_o <= 1'b0;
        wait_clk(HALF);
    endtask

    // Eight bits most significant first, then the acknowledge bit
    task automatic xfer_byte(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            xfer_bit(tx[i], rx[i]);
        end
        xfer_bit(ack_in, ack);
    endtask
endmodule

// [temp_sensor_smbus_standby_bench.sv]
// Self-checking bench of the temperature sensor core against an integer model
`timescale 1ns/1ns
module temp_sensor_smbus_standby_bench
    import temp_sensor_pkg::*;
;
    localparam int    CHAN_BENCH = 300; // Long enough to read status mid-conversion
    logic             ref_clk = 1'b0;
    logic             reset_n = 1'b0;
    logic             sleep_n = 1'b1;
    logic [SMP_W-1:0] adc_loc = '0;
    logic [SMP_W-1:0] adc_rem = '0;
    logic             scl, host_sda, dev_sda, dev_oe_n, adc_en, adc_ch, ack_b;
    logic [7:0]       rd;
    logic [31:0]      seed = 32'hD12F;
    int               n_mismatch = 0;
    int               total_checks = 0;
    int               exp_reg[4];
    wire              sda = host_sda & (dev_oe_n | dev_sda); // Pulled-up open-drain wire

    // Clock
    always #10 ref_clk = ~ref_clk;

    // Design and host model
    temp_sensor_smbus_standby #(.PERIOD_CYC(200), .CHAN_CYC(CHAN_BENCH)) i_temp_sensor_smbus_standby (
        .REF_CLK_I(ref_clk), .RESET_N_I(reset_n), .CLK_EN_I(1'b1), .SMB_CLK_I(scl), .SMB_DATA_I(sda),
        .SMB_DATA_O(dev_sda), .SMB_DATA_OE_N_O(dev_oe_n), .SLEEP_REQUEST_PIN_N_I(sleep_n),
        .ADC_LOCAL_I(adc_loc), .ADC_REMOTE_I(adc_rem), .ADC_ENABLE_O(adc_en), .ADC_CHANNEL_O(adc_ch));
    smbus_host_model i_smbus_host_model (.clk_i(ref_clk), .sda_i(sda), .scl_o(scl), .sda_o(host_sda));

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // Compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        total_checks++;
        if (seen !== want) begin
            n_mismatch++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, want);
        end
    endtask

    // Fresh random converter samples
    task automatic new_samples();
        seed = xorshift(seed);
        adc_loc <= seed[10:0];
        adc_rem <= seed[26:16];
    endtask

    // Model commit of both channels; fractions only at slow rates
    task automatic commit(input int slow);
        exp_reg[0] = int'(adc_loc) / 8;
        exp_reg[1] = int'(adc_rem) / 8;
        exp_reg[2] = slow * (int'(adc_rem) % 8) * 32;
        exp_reg[3] = slow * (int'(adc_loc) % 8) * 32;
    endtask

    // Bus transfer pieces
    task automatic put(input logic [7:0] b);
        i_smbus_host_model.xfer_byte(b, 1'b1, rd, ack_b);
        check({7'h00, ack_b}, 8'h00);
    endtask
    task automatic open_addr(input logic rd_bit);
        i_smbus_host_model.start();
        put({DEV_ADDR, rd_bit});
    endtask
    task automatic wr(input logic [7:0] cmd, input logic [7:0] data, input logic with_data);
        open_addr(1'b0);
        put(cmd);
        if (with_data) put(data);
        i_smbus_host_model.stop();
    endtask
    task automatic rd_reg(input logic [7:0] cmd, input logic recv);
        if (!recv) begin
            open_addr(1'b0);
            put(cmd);
        end
        open_addr(1'b1);
        i_smbus_host_model.xfer_byte(8'hFF, 1'b1, rd, ack_b);
        i_smbus_host_model.stop();
    endtask
    task automatic read_all();
        logic [7:0] cmds [4] = '{CMD_LOCAL_INT, CMD_REMOTE_INT, CMD_REMOTE_FRAC, CMD_LOCAL_FRAC};
        for (int i = 0; i < 4; i++) begin
            rd_reg(cmds[i], 1'b0);
            check(rd, 8'(exp_reg[i]));
        end
    endtask

    // Converter activity checks
    task automatic wait_en(input logic v);
        int hi = 0;
        for (int i = 0; i < 2000 && adc_en !== v; i++) begin
            hi += int'(adc_ch === 1'b1);
            @(posedge ref_clk);
        end
        check({7'h00, adc_en}, {7'h00, v});
        if (v) check({7'h00, adc_ch}, 8'h00);
        else check(8'(hi == CHAN_BENCH), 8'h01);
    endtask
    task automatic hold_low(input int n);
        int hits = 0;
        repeat (n) begin
            @(posedge ref_clk);
            if (adc_en !== 1'b0) hits++;
        end
        check(8'(hits), 8'h00);
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Watchdog
    initial begin
        #(20 * 60000);
        n_mismatch++;
        complete_run();
    end

    // Main sequence
    initial begin
        repeat (8) @(posedge ref_clk);
        reset_n <= 1'b1;
        new_samples();
        wait_en(1'b1);
        wait_en(1'b0);
        commit(0);
        read_all();
        wr(CMD_CONFIG_WR, 8'h40, 1'b1);
        wr(CMD_RATE_WR, RATE_EXT_MAX, 1'b1);
        new_samples();
        hold_low(900);
        read_all();
        wr(CMD_ONE_SHOT, 8'h00, 1'b0);
        wait_en(1'b1);
        wait_en(1'b0);
        commit(1);
        read_all();
        rd_reg(8'h00, 1'b1);
        check(rd, 8'(exp_reg[3]));
        rd_reg(CMD_STATUS, 1'b0);
        check(rd, 8'h00);
        sleep_n <= 1'b0;
        new_samples();
        wr(CMD_ONE_SHOT, 8'h00, 1'b0);
        wr(CMD_CONFIG_WR, 8'h00, 1'b1);
        hold_low(900);
        read_all();
        sleep_n <= 1'b1;
        wait_en(1'b1);
        rd_reg(CMD_STATUS, 1'b0);
        check(rd, 8'h80);
        sleep_n <= 1'b0;
        repeat (3) @(posedge ref_clk);
        hold_low(300);
        read_all();
        complete_run();
    end
endmodule
